//--- rtl/vspc_pkg.sv
package vspc_pkg;
	// register word width and indices (byte address is four times the index)
	localparam int REG_W = 8;
	localparam int IDX_W = 10;
	localparam logic [IDX_W-1:0] IDX_OUTEN = 10'h002;
	localparam logic [IDX_W-1:0] IDX_EDFMT = 10'h030;
	localparam logic [IDX_W-1:0] IDX_EDCTL = 10'h034;
	localparam logic [IDX_W-1:0] IDX_SDMODE = 10'h08A;
	localparam logic [IDX_W-1:0] IDX_STD = 10'h040;
	localparam logic [IDX_W-1:0] IDX_STATUS = 10'h041;
	// field positions
	localparam int OUTEN_ED_BIT = 7;
	localparam int OUTEN_SD_BIT = 6;
	localparam int EDFMT_EMB_BIT = 2;
	localparam int EDCTL_HCTR_BIT = 1;
	localparam int EDCTL_VCTR_BIT = 2;
	localparam int SDMODE_LSB = 0;
	localparam int SDMODE_W = 3;
	localparam int STD_INTERLACED_BIT = 0;
	localparam int STD_525P_BIT = 1;
	// values after reset
	localparam logic [REG_W-1:0] RST_OUTEN = 8'h00;
	localparam logic [REG_W-1:0] RST_EDFMT = 8'h00;
	localparam logic [REG_W-1:0] RST_EDCTL = 8'h00;
	localparam logic [REG_W-1:0] RST_SDMODE = 8'h00;
	localparam logic [REG_W-1:0] RST_STD = 8'h00;
	// slave timing modes that turn the sd pins into inputs
	localparam logic [SDMODE_W-1:0] SDMODE_SLAVE1 = 3'h1;
	localparam logic [SDMODE_W-1:0] SDMODE_SLAVE3 = 3'h3;
	// embedded timing code words and flag positions
	localparam int PIX_W = 10;
	localparam logic [PIX_W-1:0] AV_PREAMBLE = 10'h3FF;
	localparam logic [PIX_W-1:0] AV_ZERO = 10'h000;
	localparam int AV_F_BIT = 8;
	localparam int AV_V_BIT = 7;
	localparam int AV_H_BIT = 6;
	// counter based sync shape, in pixel clocks and lines
	localparam int HSYNC_OFFSET_CYC = 4;
	localparam int HSYNC_WIDTH_CYC = 40;
	localparam int VSYNC_START_LINE = 0;
	localparam int VSYNC_LINES = 5;
	localparam int CNT_W = 12;
	// embedded decoder states
	typedef enum logic [1:0] {
		AV_HUNT,
		AV_GOT_PRE,
		AV_GOT_Z1,
		AV_GOT_Z2
	} vspc_avstate_type;
endpackage : vspc_pkg

//--- rtl/vspc_timing_if.sv
`timescale 1ns/1ps
interface vspc_timing_if;
	logic lineMark;
	logic frameMark;
	logic embV;
	logic is525p;
	logic ctrHsyncN;
	logic ctrVsyncN;
	modport gen (
		input lineMark,
		input frameMark,
		input embV,
		input is525p,
		output ctrHsyncN,
		output ctrVsyncN
	);
	modport ctl (
		output lineMark,
		output frameMark,
		output embV,
		output is525p,
		input ctrHsyncN,
		input ctrVsyncN
	);
endinterface : vspc_timing_if

//--- rtl/vspc_timing_gen.sv
`timescale 1ns/1ps
module vspc_timing_gen #(
	parameter int HSYNC_OFFSET = vspc_pkg::HSYNC_OFFSET_CYC,
	parameter int HSYNC_WIDTH = vspc_pkg::HSYNC_WIDTH_CYC,
	parameter int VSYNC_START = vspc_pkg::VSYNC_START_LINE,
	parameter int VSYNC_COUNT = vspc_pkg::VSYNC_LINES,
	parameter int CW = vspc_pkg::CNT_W
) (
	input wire logic clk,
	input wire logic rst,
	vspc_timing_if.gen tim
);
	localparam logic [CW-1:0] H_ON = CW'(HSYNC_OFFSET);
	localparam logic [CW-1:0] H_OFF = CW'(HSYNC_OFFSET + HSYNC_WIDTH);
	localparam logic [CW-1:0] V_ON = CW'(VSYNC_START);
	localparam logic [CW-1:0] V_OFF = CW'(VSYNC_START + VSYNC_COUNT);
	localparam logic [CW-1:0] CNT_MAX = {CW{1'b1}};

	logic [CW-1:0] hCount_reg, hCount_next;
	logic [CW-1:0] vCount_reg, vCount_next;
	logic hSyncN_reg, hSyncN_next;
	logic vSyncN_reg, vSyncN_next;

	always_comb begin
		hCount_next = hCount_reg;
		vCount_next = vCount_reg;
		// counters restart on the embedded sync edge so the pulses start HSYNC_OFFSET clocks or VSYNC_START lines after it
		if (tim.lineMark) begin
			hCount_next = '0; // RULE9
		end else if (hCount_reg != CNT_MAX) begin
			hCount_next = hCount_reg + 1'b1;
		end
		if (tim.frameMark) begin
			vCount_next = '0; // RULE14
		end else if (tim.lineMark && vCount_reg != CNT_MAX) begin
			vCount_next = vCount_reg + 1'b1;
		end
		hSyncN_next = !(hCount_next >= H_ON && hCount_next < H_OFF); // RULE8
		if (tim.is525p) begin
			vSyncN_next = !tim.embV; // RULE13
		end else begin
			vSyncN_next = !(vCount_next >= V_ON && vCount_next < V_OFF); // RULE13
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			hCount_reg <= CNT_MAX;
			vCount_reg <= CNT_MAX;
			hSyncN_reg <= 1'b1;
			vSyncN_reg <= 1'b1;
		end else begin
			hCount_reg <= hCount_next;
			vCount_reg <= vCount_next;
			hSyncN_reg <= hSyncN_next;
			vSyncN_reg <= vSyncN_next;
		end
	end

	assign tim.ctrHsyncN = hSyncN_reg;
	assign tim.ctrVsyncN = vSyncN_reg;
endmodule : vspc_timing_gen

//--- rtl/vspc_top.sv
`timescale 1ns/1ps
// What this block does
// (RULE1) frame timing comes from embedded codes or from external sync and blank pins
// (RULE2) sd sync pins are inputs only in slave modes 1-3 with both outputs off
// (RULE3) ed/hd sync pins are accepted when the input format bit is zero
// (RULE4) sd enable alone drives sd hsync and vsync on the sd pins
// (RULE5) ed/hd enable drives ed/hd syncs on sd pins regardless of sd enable
// (RULE6) both enables off leaves the sd sync pins undriven
// (RULE7) ed/hd hsync from embedded H over line blanking, or external hsync
// (RULE8) hsync control set makes hsync from the horizontal counter
// (RULE9) hsync pulse starts aligned with the embedded sync edge; the counter hsync here starts HSYNC_OFFSET (4) clocks after it
// (RULE10) format zero, vsync control clear forwards external ed/hd vsync or field
// (RULE11) format one on interlaced standards outputs the embedded F flag
// (RULE12) format one on progressive standards outputs vsync from embedded V
// (RULE13) vsync control set uses the vertical counter; 525p spans vertical blanking
// (RULE14) vsync pulse starts aligned with the embedded vertical sync edge
// (RULE15) sd enable alone drives the sd vsync or field signal on the vsync pin
module vspc_top (
	input wire logic clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [vspc_pkg::PIX_W-1:0] pixelData,
	input wire logic sdTimHsyncN,
	input wire logic sdTimVsyncN,
	input wire logic sdHsyncPinIn,
	output logic sdHsyncPinOut,
	output logic sdHsyncPinOeN,
	input wire logic sdVsyncPinIn,
	output logic sdVsyncPinOut,
	output logic sdVsyncPinOeN,
	input wire logic edHsyncPin,
	input wire logic edVsyncPin,
	input wire logic edBlankPin,
	output logic sdSlaveValid,
	output logic sdSlaveHsyncN,
	output logic sdSlaveVsyncN,
	output logic edExtValid,
	output logic edExtHsyncN,
	output logic edExtVsyncN,
	output logic edExtBlankN,
	output logic embHFlag,
	output logic embVFlag,
	output logic embFFlag
);
	localparam int NPIN = 5;
	localparam int P_SDH = 0;
	localparam int P_SDV = 1;
	localparam int P_EDH = 2;
	localparam int P_EDV = 3;
	localparam int P_EDB = 4;

	// ---------------- pin input synchronisers ----------------
	logic [NPIN-1:0] pinRaw;
	logic [NPIN-1:0] pinS1_reg, pinS1_next;
	logic [NPIN-1:0] pinS2_reg, pinS2_next;
	logic [NPIN-1:0] pinS3_reg, pinS3_next;
	logic [NPIN-1:0] pinF_reg, pinF_next;

	assign pinRaw = {edBlankPin, edVsyncPin, edHsyncPin, sdVsyncPinIn, sdHsyncPinIn};

	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++) begin : g_pin
			always_comb begin
				pinS1_next[gi] = pinRaw[gi];
				pinS2_next[gi] = pinS1_reg[gi];
				pinS3_next[gi] = pinS2_reg[gi];
				// a change counts once the second and third stage agree
				if (pinS2_reg[gi] == pinS3_reg[gi]) begin
					pinF_next[gi] = pinS3_reg[gi];
				end else begin
					pinF_next[gi] = pinF_reg[gi];
				end
			end
			always_ff @(posedge clk) begin
				if (rst) begin
					pinS1_reg[gi] <= 1'b1;
					pinS2_reg[gi] <= 1'b1;
					pinS3_reg[gi] <= 1'b1;
					pinF_reg[gi] <= 1'b1;
				end else begin
					pinS1_reg[gi] <= pinS1_next[gi];
					pinS2_reg[gi] <= pinS2_next[gi];
					pinS3_reg[gi] <= pinS3_next[gi];
					pinF_reg[gi] <= pinF_next[gi];
				end
			end
		end
	endgenerate

	// ---------------- register bus ----------------
	logic [vspc_pkg::REG_W-1:0] outEn_reg, outEn_next;
	logic [vspc_pkg::REG_W-1:0] edFmt_reg, edFmt_next;
	logic [vspc_pkg::REG_W-1:0] edCtl_reg, edCtl_next;
	logic [vspc_pkg::REG_W-1:0] sdMode_reg, sdMode_next;
	logic [vspc_pkg::REG_W-1:0] std_reg, std_next;
	logic wrPend_reg, wrPend_next;
	logic [vspc_pkg::IDX_W-1:0] wrIdx_reg, wrIdx_next;
	logic [31:0] rdData_reg, rdData_next;
	logic [vspc_pkg::REG_W-1:0] status;
	logic [vspc_pkg::REG_W-1:0] rdVal;
	logic [vspc_pkg::REG_W-1:0] wrByte;
	logic [vspc_pkg::IDX_W-1:0] addrIdx;
	logic accept;

	assign addrIdx = haddr[vspc_pkg::IDX_W+1:2];
	assign accept = hsel && htrans[1] && hready;
	assign wrByte = hwdata[vspc_pkg::REG_W-1:0];

	// readback of one register; a write still in its data phase is forwarded
	function automatic logic [vspc_pkg::REG_W-1:0] regValue(
		input logic [vspc_pkg::IDX_W-1:0] idx,
		input logic [vspc_pkg::REG_W-1:0] oe,
		input logic [vspc_pkg::REG_W-1:0] fm,
		input logic [vspc_pkg::REG_W-1:0] ct,
		input logic [vspc_pkg::REG_W-1:0] sm,
		input logic [vspc_pkg::REG_W-1:0] sd,
		input logic [vspc_pkg::REG_W-1:0] st
	);
		logic [vspc_pkg::REG_W-1:0] v;
		v = '0;
		case (idx)
			vspc_pkg::IDX_OUTEN: v = oe;
			vspc_pkg::IDX_EDFMT: v = fm;
			vspc_pkg::IDX_EDCTL: v = ct;
			vspc_pkg::IDX_SDMODE: v = sm;
			vspc_pkg::IDX_STD: v = sd;
			vspc_pkg::IDX_STATUS: v = st;
			default: v = '0;
		endcase
		return v;
	endfunction : regValue

	always_comb begin
		outEn_next = outEn_reg;
		edFmt_next = edFmt_reg;
		edCtl_next = edCtl_reg;
		sdMode_next = sdMode_reg;
		std_next = std_reg;
		if (wrPend_reg) begin
			case (wrIdx_reg)
				vspc_pkg::IDX_OUTEN: outEn_next = wrByte;
				vspc_pkg::IDX_EDFMT: edFmt_next = wrByte;
				vspc_pkg::IDX_EDCTL: edCtl_next = wrByte;
				vspc_pkg::IDX_SDMODE: sdMode_next = wrByte;
				vspc_pkg::IDX_STD: std_next = wrByte;
				default: outEn_next = outEn_reg;
			endcase
		end
		wrPend_next = accept && hwrite;
		wrIdx_next = accept ? addrIdx : wrIdx_reg;
		rdVal = regValue(addrIdx, outEn_next, edFmt_next, edCtl_next, sdMode_next, std_next,
			status);
		rdData_next = rdData_reg;
		if (accept && !hwrite) begin
			rdData_next = {{(32 - vspc_pkg::REG_W){1'b0}}, rdVal};
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			outEn_reg <= vspc_pkg::RST_OUTEN;
			edFmt_reg <= vspc_pkg::RST_EDFMT;
			edCtl_reg <= vspc_pkg::RST_EDCTL;
			sdMode_reg <= vspc_pkg::RST_SDMODE;
			std_reg <= vspc_pkg::RST_STD;
			wrPend_reg <= 1'b0;
			wrIdx_reg <= '0;
			rdData_reg <= '0;
		end else begin
			outEn_reg <= outEn_next;
			edFmt_reg <= edFmt_next;
			edCtl_reg <= edCtl_next;
			sdMode_reg <= sdMode_next;
			std_reg <= std_next;
			wrPend_reg <= wrPend_next;
			wrIdx_reg <= wrIdx_next;
			rdData_reg <= rdData_next;
		end
	end

	assign hrdata = rdData_reg;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// ---------------- control decode ----------------
	logic edEn, sdEn, embFmt, hCtr, vCtr, interlaced, is525p, sdSlaveMode;
	logic [vspc_pkg::SDMODE_W-1:0] sdModeSel;

	assign edEn = outEn_reg[vspc_pkg::OUTEN_ED_BIT];
	assign sdEn = outEn_reg[vspc_pkg::OUTEN_SD_BIT];
	assign embFmt = edFmt_reg[vspc_pkg::EDFMT_EMB_BIT];
	assign hCtr = edCtl_reg[vspc_pkg::EDCTL_HCTR_BIT];
	assign vCtr = edCtl_reg[vspc_pkg::EDCTL_VCTR_BIT];
	assign interlaced = std_reg[vspc_pkg::STD_INTERLACED_BIT];
	assign is525p = std_reg[vspc_pkg::STD_525P_BIT];
	assign sdModeSel = sdMode_reg[vspc_pkg::SDMODE_LSB +: vspc_pkg::SDMODE_W];
	assign sdSlaveMode = sdModeSel >= vspc_pkg::SDMODE_SLAVE1
		&& sdModeSel <= vspc_pkg::SDMODE_SLAVE3 && !edEn && !sdEn; // RULE2

	// ---------------- embedded timing code decoder ----------------
	vspc_pkg::vspc_avstate_type avState_reg, avState_next;
	logic fFlag_reg, fFlag_next;
	logic vFlag_reg, vFlag_next;
	logic hFlag_reg, hFlag_next;
	logic lineMark_reg, lineMark_next;
	logic frameMark_reg, frameMark_next;

	always_comb begin
		avState_next = avState_reg;
		fFlag_next = fFlag_reg;
		vFlag_next = vFlag_reg;
		hFlag_next = hFlag_reg;
		case (avState_reg)
			vspc_pkg::AV_HUNT: begin
				avState_next = vspc_pkg::AV_HUNT;
			end
			vspc_pkg::AV_GOT_PRE: begin
				avState_next = (pixelData == vspc_pkg::AV_ZERO) ? vspc_pkg::AV_GOT_Z1
					: vspc_pkg::AV_HUNT;
			end
			vspc_pkg::AV_GOT_Z1: begin
				avState_next = (pixelData == vspc_pkg::AV_ZERO) ? vspc_pkg::AV_GOT_Z2
					: vspc_pkg::AV_HUNT;
			end
			vspc_pkg::AV_GOT_Z2: begin
				avState_next = vspc_pkg::AV_HUNT;
				if (pixelData[vspc_pkg::PIX_W-1]) begin
					fFlag_next = pixelData[vspc_pkg::AV_F_BIT]; // RULE1
					vFlag_next = pixelData[vspc_pkg::AV_V_BIT]; // RULE1
					hFlag_next = pixelData[vspc_pkg::AV_H_BIT]; // RULE1
				end
			end
			default: begin
				avState_next = vspc_pkg::AV_HUNT;
			end
		endcase
		if (pixelData == vspc_pkg::AV_PREAMBLE) begin
			avState_next = vspc_pkg::AV_GOT_PRE;
		end
		lineMark_next = hFlag_next && !hFlag_reg; // RULE9
		frameMark_next = vFlag_next && !vFlag_reg; // RULE14
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			avState_reg <= vspc_pkg::AV_HUNT;
			fFlag_reg <= 1'b0;
			vFlag_reg <= 1'b0;
			hFlag_reg <= 1'b0;
			lineMark_reg <= 1'b0;
			frameMark_reg <= 1'b0;
		end else begin
			avState_reg <= avState_next;
			fFlag_reg <= fFlag_next;
			vFlag_reg <= vFlag_next;
			hFlag_reg <= hFlag_next;
			lineMark_reg <= lineMark_next;
			frameMark_reg <= frameMark_next;
		end
	end

	// ---------------- counter based sync generator ----------------
	vspc_timing_if tim ();

	assign tim.lineMark = lineMark_reg;
	assign tim.frameMark = frameMark_reg;
	assign tim.embV = vFlag_reg;
	assign tim.is525p = is525p;

	vspc_timing_gen u_timing (
		.clk(clk),
		.rst(rst),
		.tim(tim)
	);

	// ---------------- sync output selection ----------------
	logic hOut_reg, hOut_next;
	logic vOut_reg, vOut_next;
	logic oeN_reg, oeN_next;
	logic edExtOk;

	assign edExtOk = !embFmt; // RULE3

	always_comb begin
		hOut_next = 1'b1;
		vOut_next = 1'b1;
		oeN_next = 1'b1; // RULE6
		if (edEn) begin
			oeN_next = 1'b0; // RULE5
			if (hCtr) begin
				hOut_next = tim.ctrHsyncN; // RULE8
			end else if (embFmt) begin
				hOut_next = !hFlag_reg; // RULE7
			end else begin
				hOut_next = pinF_reg[P_EDH]; // RULE7
			end
			if (vCtr) begin
				vOut_next = tim.ctrVsyncN; // RULE13
			end else if (!embFmt) begin
				vOut_next = pinF_reg[P_EDV]; // RULE10
			end else if (interlaced) begin
				vOut_next = fFlag_reg; // RULE11
			end else begin
				vOut_next = !vFlag_reg; // RULE12
			end
		end else if (sdEn) begin
			oeN_next = 1'b0; // RULE4
			hOut_next = sdTimHsyncN; // RULE4
			vOut_next = sdTimVsyncN; // RULE15
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			hOut_reg <= 1'b1;
			vOut_reg <= 1'b1;
			oeN_reg <= 1'b1;
		end else begin
			hOut_reg <= hOut_next;
			vOut_reg <= vOut_next;
			oeN_reg <= oeN_next;
		end
	end

	assign sdHsyncPinOut = hOut_reg;
	assign sdVsyncPinOut = vOut_reg;
	assign sdHsyncPinOeN = oeN_reg;
	assign sdVsyncPinOeN = oeN_reg;

	// ---------------- timing handed to the video paths ----------------
	assign sdSlaveValid = sdSlaveMode;
	assign sdSlaveHsyncN = sdSlaveMode ? pinF_reg[P_SDH] : 1'b1; // RULE2
	assign sdSlaveVsyncN = sdSlaveMode ? pinF_reg[P_SDV] : 1'b1; // RULE2
	assign edExtValid = edExtOk;
	assign edExtHsyncN = edExtOk ? pinF_reg[P_EDH] : 1'b1; // RULE3
	assign edExtVsyncN = edExtOk ? pinF_reg[P_EDV] : 1'b1; // RULE3
	assign edExtBlankN = pinF_reg[P_EDB]; // RULE1
	assign embHFlag = hFlag_reg;
	assign embVFlag = vFlag_reg;
	assign embFFlag = fFlag_reg;

	assign status = {vOut_reg, hOut_reg, fFlag_reg, vFlag_reg, hFlag_reg, edEn, !oeN_reg,
		sdSlaveMode};
endmodule : vspc_top

//--- dv/vspc_src_model.sv
`timescale 1ns/1ps
module vspc_src_model #(
	parameter int LW = 64,
	parameter int LN = 8
) (
	input wire logic clk,
	input wire logic rst,
	output logic [vspc_pkg::PIX_W-1:0] pixelData,
	output logic sdTimHsyncN,
	output logic sdTimVsyncN,
	output logic sdHsyncSrcN,
	output logic sdVsyncSrcN,
	output logic edHsyncPin,
	output logic edVsyncPin,
	output logic edBlankPin
);
	int hc;
	int vc;
	int k;
	always_ff @(posedge clk) begin
		hc <= (rst || hc == LW - 1) ? 0 : hc + 1;
		if (rst) begin
			vc <= 0;
		end else if (hc == LW - 1) begin
			vc <= (vc + 1) % LN;
		end
	end
	// codes at 0..3 open line blanking, at 20..23 close it
	always_comb begin
		k = (hc >= 20) ? hc - 20 : hc;
		pixelData = 10'h200;
		if (hc < 24 && k < 4) begin
			pixelData = (k == 0) ? 10'h3FF : 10'h000;
		end
		if (k == 3 && hc < 24) begin
			pixelData = {1'b1, vc >= LN / 2, vc < 2, hc < 20, 6'h00};
		end
	end
	// separate sync lines, active low
	assign sdTimHsyncN = !(hc < 8);
	assign sdTimVsyncN = !(vc == 0);
	assign sdHsyncSrcN = sdTimHsyncN;
	assign sdVsyncSrcN = sdTimVsyncN;
	assign edHsyncPin = !(hc < 12);
	assign edVsyncPin = !(vc < 2);
	assign edBlankPin = !(hc < 24);
endmodule : vspc_src_model

//--- dv/vspc_top_sva.sv
`timescale 1ns/1ps
module vspc_top_sva (
	input wire logic clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic sdTimHsyncN,
	input wire logic sdTimVsyncN,
	input wire logic sdHsyncPinOut,
	input wire logic sdHsyncPinOeN,
	input wire logic sdVsyncPinOut,
	input wire logic sdVsyncPinOeN,
	input wire logic sdSlaveValid,
	input wire logic sdSlaveHsyncN,
	input wire logic sdSlaveVsyncN,
	input wire logic edExtValid,
	input wire logic edExtHsyncN,
	input wire logic edExtVsyncN,
	input wire logic embHFlag,
	input wire logic embVFlag,
	input wire logic embFFlag
);
	logic wp;
	logic [9:0] wi;
	logic [7:0] oe, fm, ct, st;
	// shadow of the control bytes rebuilt from bus writes
	always_ff @(posedge clk) begin
		wp <= !rst && hsel && htrans[1] && hready && hwrite;
		wi <= haddr[11:2];
		if (rst) begin
			oe <= 8'h00;
			fm <= 8'h00;
			ct <= 8'h00;
			st <= 8'h00;
		end else if (wp) begin
			if (wi == vspc_pkg::IDX_OUTEN) oe <= hwdata[7:0];
			if (wi == vspc_pkg::IDX_EDFMT) fm <= hwdata[7:0];
			if (wi == vspc_pkg::IDX_EDCTL) ct <= hwdata[7:0];
			if (wi == vspc_pkg::IDX_STD) st <= hwdata[7:0];
		end
	end
	wire sdOn = oe[7:6] == 2'h1;
	wire off = oe[7:6] == 2'h0;
	wire edOn = oe[7];
	wire embH = edOn && fm[2] && !ct[1];
	wire embV = edOn && fm[2] && !ct[2] && !st[0];
	wire embF = edOn && fm[2] && !ct[2] && st[0];
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_oe_pair: assert property (sdHsyncPinOeN == sdVsyncPinOeN)
		else $error("sync pin enables differ");
	a_off_float: assert property ($past(off) |-> sdHsyncPinOeN && sdHsyncPinOut && sdVsyncPinOut)
		else $error("sync pins driven while off");
	a_ed_drive: assert property ($past(edOn) |-> !sdHsyncPinOeN)
		else $error("ed/hd enable not driving pins");
	a_sd_follow: assert property ($past(sdOn) |-> sdHsyncPinOut == $past(sdTimHsyncN)
		&& sdVsyncPinOut == $past(sdTimVsyncN))
		else $error("sd syncs not forwarded");
	a_emb_hflag: assert property ($past(embH) |-> sdHsyncPinOut == !$past(embHFlag))
		else $error("hsync not from embedded H");
	a_emb_vflag: assert property ($past(embV) |-> sdVsyncPinOut == !$past(embVFlag))
		else $error("vsync not from embedded V");
	a_emb_field: assert property ($past(embF) |-> sdVsyncPinOut == $past(embFFlag))
		else $error("field not from embedded F");
	a_slave_dir: assert property (sdSlaveValid && $past(sdSlaveValid) |-> sdHsyncPinOeN)
		else $error("pins driven in slave mode");
	a_slave_idle: assert property (!sdSlaveValid |-> sdSlaveHsyncN && sdSlaveVsyncN)
		else $error("slave syncs active while not valid");
	a_ext_valid: assert property (edExtValid == !fm[2])
		else $error("external sync valid wrong");
	a_ext_idle: assert property (!edExtValid |-> edExtHsyncN && edExtVsyncN)
		else $error("external syncs active while unused");
endmodule : vspc_top_sva

//--- dv/vspc_top_tb.sv
`timescale 1ns/1ps
module vspc_top_tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h00000000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h00000000;
	logic [31:0] hrdata, obs, r;
	logic hreadyout, hresp;
	wire hready = hreadyout;
	logic [vspc_pkg::PIX_W-1:0] pixelData;
	logic sdTimHsyncN, sdTimVsyncN, sdHsyncSrcN, sdVsyncSrcN;
	logic sdHsyncPinOut, sdHsyncPinOeN, sdVsyncPinOut, sdVsyncPinOeN;
	logic edHsyncPin, edVsyncPin, edBlankPin, embHFlag, embVFlag, embFFlag, edExtBlankN;
	logic sdSlaveValid, sdSlaveHsyncN, sdSlaveVsyncN, edExtValid, edExtHsyncN, edExtVsyncN;
	wire sdHsyncPinIn = sdHsyncPinOeN ? sdHsyncSrcN : sdHsyncPinOut;
	wire sdVsyncPinIn = sdVsyncPinOeN ? sdVsyncSrcN : sdVsyncPinOut;
	int n_errors = 0;
	int n_tests = 0;
	logic [31:0] q[$];
	event got;
	logic [2:0] m, r0;
	logic [7:0] tOe[7] = '{8'h40, 8'hC0, 8'h80, 8'h80, 8'h80, 8'h80, 8'h00};
	logic [7:0] tFm[7] = '{8'h00, 8'h00, 8'h04, 8'h04, 8'h00, 8'h00, 8'h00};
	logic [7:0] tCt[7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h06, 8'h06, 8'h06};
	logic [7:0] tSt[7] = '{8'h01, 8'h00, 8'h01, 8'h00, 8'h00, 8'h02, 8'h00};
	logic [11:0] tH[7] = '{12'h040, 12'h060, 12'h0A0, 12'h0A0, 12'h140, 12'h140, 12'h000};
	logic [11:0] tV[7] = '{12'h040, 12'h080, 12'h100, 12'h080, 12'h140, 12'h080, 12'h000};
	vspc_top u_dut (.*);
	vspc_src_model u_src (.*);
	initial forever #50 clk = ~clk;
	always @(got) begin
		n_tests++;
		if (obs !== q[0]) begin
			n_errors++;
			$display("ERROR %0t: got %h expected %h", $time, obs, q[0]);
		end
		void'(q.pop_front());
	end
	task automatic tally_and_finish;
		// let the compare process take the last note first
		@(negedge clk);
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [31:0] o, input logic [31:0] e);
		q.push_back(e);
		obs = o;
		-> got;
	endtask : chk
	task automatic wt;
		int n;
		n = 0;
		@(posedge clk);
		while (hreadyout !== 1'b1) begin
			n++;
			if (n > 50) begin
				n_errors++;
				$display("ERROR %0t: bus timeout", $time);
				tally_and_finish();
			end
			@(posedge clk);
		end
	endtask : wt
	task automatic bus(input logic w, input logic [9:0] idx, input logic [7:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {20'h00000, idx, 2'h0};
		wt();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h000000, d};
		wt();
		r = hrdata;
	endtask : bus
	task automatic rd(input logic [9:0] idx, input logic [31:0] e);
		bus(1'b0, idx, 8'h00);
		chk({r[31] | hresp, r[30:0]}, e);
	endtask : rd
	// count low cycles of the slave syncs and the blank input over one frame
	task automatic slv(input logic [31:0] e);
		logic [9:0] lh;
		logic [9:0] lv;
		logic [9:0] lb;
		lh = 10'h000;
		lv = 10'h000;
		lb = 10'h000;
		repeat (8) @(posedge clk);
		repeat (512) begin
			@(negedge clk);
			if (sdSlaveHsyncN === 1'b0) lh++;
			if (sdSlaveVsyncN === 1'b0) lv++;
			if (edExtBlankN === 1'b0) lb++;
		end
		chk({2'h0, lh, lv, lb}, e);
	endtask : slv
	// count low cycles of both sync pins over one whole frame
	task automatic win(input logic [31:0] e);
		logic [11:0] lh;
		logic [11:0] lv;
		lh = 12'h000;
		lv = 12'h000;
		repeat (600) @(posedge clk);
		repeat (512) begin
			@(negedge clk);
			if (sdHsyncPinOut === 1'b0) lh++;
			if (sdVsyncPinOut === 1'b0) lv++;
		end
		chk({6'h00, sdHsyncPinOeN, sdVsyncPinOeN, lh, lv}, e);
	endtask : win
	initial begin
		void'($urandom(39719));
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rd(vspc_pkg::IDX_OUTEN, 32'h00000000);
		rd(vspc_pkg::IDX_EDFMT, 32'h00000000);
		rd(vspc_pkg::IDX_EDCTL, 32'h00000000);
		rd(vspc_pkg::IDX_SDMODE, 32'h00000000);
		rd(10'h3FF, 32'h00000000);
		$display("test reset done");
		r0 = 3'($urandom % 8);
		for (int i = 0; i < 8; i++) begin
			m = 3'(i) + r0;
			bus(1'b1, vspc_pkg::IDX_SDMODE, {5'h00, m});
			@(negedge clk);
			chk({31'h0, sdSlaveValid}, {31'h0, m >= 3'h1 && m <= 3'h3});
			rd(vspc_pkg::IDX_SDMODE, {29'h0, m});
		end
		bus(1'b1, vspc_pkg::IDX_SDMODE, 8'h02);
		slv({2'h0, 10'h040, 10'h040, 10'h0C0});
		bus(1'b1, vspc_pkg::IDX_OUTEN, 8'h40);
		@(negedge clk);
		chk({31'h0, sdSlaveValid}, 32'h00000000);
		bus(1'b1, vspc_pkg::IDX_SDMODE, 8'h00);
		$display("test slave done");
		for (int i = 0; i < 7; i++) begin
			bus(1'b1, vspc_pkg::IDX_STD, tSt[i]);
			bus(1'b1, vspc_pkg::IDX_EDFMT, tFm[i]);
			bus(1'b1, vspc_pkg::IDX_EDCTL, tCt[i]);
			bus(1'b1, vspc_pkg::IDX_OUTEN, tOe[i]);
			rd(vspc_pkg::IDX_OUTEN, {24'h000000, tOe[i]});
			win({6'h00, {2{tOe[i][7:6] == 2'h0}}, tH[i], tV[i]});
			$display("test sync %0d done", i);
		end
		tally_and_finish();
	end
endmodule : vspc_top_tb
bind vspc_top vspc_top_sva u_sva (.*);
